// file: rtl/ext_irq_pkg.sv
// Purpose: Shared constants for the external interrupt input logic.
// Assumes: 8-bit special-function-register bus, 8-pin port 0.
// Notes:   Every offset and field position lives here; the pending-flag reset value of 0 sits in irq_channel.

package ext_irq_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [7:0] CFG_ADDR = 8'he4;  // ext_irq_pin_config
    localparam logic [7:0] TIMER_CONTROL_REG_ADDR = 8'h88; // timer_control_reg, low nibble held here

    // ********************************************************
    // ext_irq_pin_config fields
    // ********************************************************
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam int A_SEL_LSB = 0;
    localparam int B_SEL_LSB = 4;
    localparam int SEL_W = 3;
    localparam int A_POL_BIT = 3;
    localparam int B_POL_BIT = 7;

    // ********************************************************
    // timer_control_reg fields owned by this block
    // ********************************************************
    localparam int A_MODE_BIT = 0;
    localparam int A_PEND_BIT = 1;
    localparam int B_MODE_BIT = 2;
    localparam int B_PEND_BIT = 3;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // ********************************************************
    // Widths and timing
    // ********************************************************
    localparam int PORT_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage

// file: rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pins.
// Assumes: Pins change slowly compared with the system clock.
// Notes:   First stage is read only by the second stage.

`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Pins in, synchronised copy out
    input wire logic [WIDTH-1:0] pins_i,
    output logic [WIDTH-1:0] pins_sync_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] stable_r;
    logic [WIDTH-1:0] stable_nxt;

    // Next values of both stages
    always_comb begin
        meta_nxt = pins_i;
        stable_nxt = meta_r;
    end

    // Registers; metastable stage feeds nothing but the stable stage
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            stable_r <= stable_nxt;
        end
    end

    assign pins_sync_o = stable_r;

endmodule

`default_nettype wire

// file: rtl/irq_channel.sv
// Purpose: One external interrupt input: pin select, polarity, sense, pending flag.
// Assumes: Pins arrive already synchronised to sys_clk_i.
// Notes:   Changing polarity or pin in edge mode can itself look like an edge.

`timescale 1ns/1ps
`default_nettype none

module irq_channel
    import ext_irq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Synchronised port pins and configuration
    input wire logic [PORT_W-1:0] pins_sync_i,
    input wire logic [SEL_W-1:0] pin_select_i,
    input wire logic polarity_i,
    input wire logic edge_mode_i,
    // Core side: vector acknowledge and software write of the flag
    input wire logic ack_i,
    input wire logic sw_wr_i,
    input wire logic sw_val_i,
    // State out
    output logic pending_o,
    output logic active_o,
    output logic edge_o
);

    logic prev_r;
    logic prev_nxt;
    logic pend_r;
    logic pend_nxt;
    logic raw;

    // Pick the pin and apply polarity; a low-active pin is inverted here
    always_comb begin
        raw = pins_sync_i[pin_select_i];
        active_o = polarity_i ? raw : ~raw;
        edge_o = active_o & ~prev_r;
    end

    // Next flag value; an edge beats both the acknowledge and a software clear
    always_comb begin
        prev_nxt = active_o;
        pend_nxt = pend_r;
        if (edge_mode_i) begin
            if (sw_wr_i) begin
                pend_nxt = sw_val_i;
            end else if (ack_i) begin
                pend_nxt = 1'b0;
            end
            if (edge_o) begin
                pend_nxt = 1'b1;
            end
        end else begin
            pend_nxt = active_o;
        end
    end

    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prev_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign pending_o = pend_r;

endmodule

`default_nettype wire

// file: rtl/ext_irq_input_logic.sv
// Purpose: Front end for two external interrupt inputs taken from port-0 pins.
// Assumes: Single-cycle register bus; ack pulses come from the core's vectoring.
// Notes:   Only the low nibble of timer_control_reg lives here; upper bits read 0.

`timescale 1ns/1ps
`default_nettype none

module ext_irq_input_logic
    import ext_irq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Special-function-register bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // Port 0 pins, observed only
    input wire logic [PORT_W-1:0] port0_pins_i,
    // Core interrupt side
    input wire logic irq_a_ack_i,
    input wire logic irq_b_ack_i,
    output logic irq_a_pending_o,
    output logic irq_b_pending_o
);

    // ********************************************************
    // Declarations
    // ********************************************************
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [PORT_W-1:0] pins_sync;
    logic cfg_wr;
    logic timer_control_reg_wr;
    logic irq_a_edge_mode;
    logic irq_b_edge_mode;
    logic irq_a_polarity;
    logic irq_b_polarity;
    logic [SEL_W-1:0] irq_a_pin_select;
    logic [SEL_W-1:0] irq_b_pin_select;
    logic a_active;
    logic b_active;
    logic a_edge;
    logic b_edge;
    logic [7:0] timer_control_reg_view;

    // ********************************************************
    // Field decode
    // ********************************************************
    // Address decode for the two registers held here
    assign cfg_wr = sfr_wr_i && (sfr_addr_i == CFG_ADDR);
    assign timer_control_reg_wr = sfr_wr_i && (sfr_addr_i == TIMER_CONTROL_REG_ADDR);

    // Configuration fields steering the channels
    assign irq_a_pin_select = cfg_r[A_SEL_LSB +: SEL_W];
    assign irq_b_pin_select = cfg_r[B_SEL_LSB +: SEL_W];
    assign irq_a_polarity = cfg_r[A_POL_BIT];
    assign irq_b_polarity = cfg_r[B_POL_BIT];
    assign irq_a_edge_mode = mode_r[0];
    assign irq_b_edge_mode = mode_r[1];

    // ********************************************************
    // Configuration and sense-mode registers
    // ********************************************************
    // Plain stores; the whole byte of the config register is read/write
    always_comb begin
        cfg_nxt = cfg_r;
        mode_nxt = mode_r;
        if (cfg_wr) begin
            cfg_nxt = sfr_wdata_i;
        end
        if (timer_control_reg_wr) begin
            mode_nxt = {sfr_wdata_i[B_MODE_BIT], sfr_wdata_i[A_MODE_BIT]};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cfg_r <= CFG_RESET;
            mode_r <= MODE_RESET;
        end else begin
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ********************************************************
    // Pin synchroniser
    // ********************************************************
    // All eight pins are synchronised so a pin change never needs a resync
    pin_sync #(
        .WIDTH(PORT_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pins_i(port0_pins_i),
        .pins_sync_o(pins_sync)
    );

    // ********************************************************
    // Interrupt channels
    // ********************************************************
    // Input A channel
    irq_channel u_chan_a (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pins_sync_i(pins_sync),
        .pin_select_i(irq_a_pin_select),
        .polarity_i(irq_a_polarity),
        .edge_mode_i(irq_a_edge_mode),
        .ack_i(irq_a_ack_i),
        .sw_wr_i(timer_control_reg_wr),
        .sw_val_i(sfr_wdata_i[A_PEND_BIT]),
        .pending_o(irq_a_pending_o),
        .active_o(a_active),
        .edge_o(a_edge)
    );

    // Input B channel
    irq_channel u_chan_b (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pins_sync_i(pins_sync),
        .pin_select_i(irq_b_pin_select),
        .polarity_i(irq_b_polarity),
        .edge_mode_i(irq_b_edge_mode),
        .ack_i(irq_b_ack_i),
        .sw_wr_i(timer_control_reg_wr),
        .sw_val_i(sfr_wdata_i[B_PEND_BIT]),
        .pending_o(irq_b_pending_o),
        .active_o(b_active),
        .edge_o(b_edge)
    );

    // ********************************************************
    // Read path
    // ********************************************************
    // Low nibble of timer_control_reg as this block sees it
    always_comb begin
        timer_control_reg_view = 8'h00;
        timer_control_reg_view[A_MODE_BIT] = irq_a_edge_mode;
        timer_control_reg_view[A_PEND_BIT] = irq_a_pending_o;
        timer_control_reg_view[B_MODE_BIT] = irq_b_edge_mode;
        timer_control_reg_view[B_PEND_BIT] = irq_b_pending_o;
    end

    // Registered read data; unmapped addresses answer zero, idle holds last
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_rd_i) begin
            if (sfr_addr_i == CFG_ADDR) begin
                rdata_nxt = cfg_r;
            end else if (sfr_addr_i == TIMER_CONTROL_REG_ADDR) begin
                rdata_nxt = timer_control_reg_view;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_r <= RDATA_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata_o = rdata_r;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Config write lands on the next edge
    cfg_write_store_a: assert property (cfg_wr |=> cfg_r == $past(sfr_wdata_i))
        else $error("config write not stored");

    // Level mode flag mirrors the polarised input one cycle later
    // Skipped on the first edge out of reset, where the flag still holds its cleared value
    level_follow_a: assert property (
        !irq_a_edge_mode && $stable(irq_a_edge_mode) && $past(rstn_i)
        |-> irq_a_pending_o == $past(a_active))
        else $error("level flag A does not follow input");

    level_follow_b_a: assert property (
        !irq_b_edge_mode && $stable(irq_b_edge_mode) && $past(rstn_i)
        |-> irq_b_pending_o == $past(b_active))
        else $error("level flag B does not follow input");

    // Active edge always sets the flag, even against ack or clear
    edge_set_a: assert property (irq_a_edge_mode && a_edge |=> irq_a_pending_o)
        else $error("edge on A did not set flag");

    // Acknowledge clears an edge flag when nothing else intervenes
    ack_clear_a: assert property (
        irq_b_edge_mode && irq_b_ack_i && !b_edge && !timer_control_reg_wr |=> !irq_b_pending_o)
        else $error("ack did not clear flag B");

    // An edge flag with no cause to change keeps its value for two cycles
    edge_hold_a: assert property (
        irq_a_edge_mode && irq_a_pending_o && !irq_a_ack_i && !timer_control_reg_wr
        ##1 irq_a_edge_mode && !irq_a_ack_i && !timer_control_reg_wr |=> irq_a_pending_o)
        else $error("edge flag A dropped without cause");

    // Pin level reaches a level-mode flag three edges after it is sampled
    pin_latency_a: assert property (
        !irq_a_edge_mode && $stable(cfg_r) && $stable(irq_a_edge_mode)
        ##1 $stable(cfg_r) && $stable(irq_a_edge_mode)
        ##1 $stable(cfg_r) && $stable(irq_a_edge_mode)
        |=> irq_a_pending_o ==
            ($past(port0_pins_i[irq_a_pin_select], 3) ~^ $past(irq_a_polarity)))
        else $error("pin to flag latency wrong");

    // Config read returns the stored byte
    cfg_read_a: assert property (
        sfr_rd_i && sfr_addr_i == CFG_ADDR |=> sfr_rdata_o == $past(cfg_r))
        else $error("config read mismatch");

    // Reading timer_control_reg shows pending flags in bits 1 and 3
    timer_control_reg_read_a: assert property (
        sfr_rd_i && sfr_addr_i == TIMER_CONTROL_REG_ADDR |=>
        sfr_rdata_o[A_PEND_BIT] == $past(irq_a_pending_o)
        && sfr_rdata_o[B_PEND_BIT] == $past(irq_b_pending_o))
        else $error("pending flags misplaced");

    // Unmapped reads answer zero
    unmapped_read_a: assert property (
        sfr_rd_i && sfr_addr_i != CFG_ADDR && sfr_addr_i != TIMER_CONTROL_REG_ADDR
        |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // Reset value of config
    reset_cfg_a: assert property (
        $rose(rstn_i) |-> cfg_r == CFG_RESET)
        else $error("config reset value wrong");

    // Pending flags and read data come out of reset cleared
    reset_outputs_a: assert property (
        $rose(rstn_i) |-> !irq_a_pending_o && !irq_b_pending_o
        && sfr_rdata_o == RDATA_RESET)
        else $error("outputs not cleared by reset");

    // Active edge on B sets its flag whatever else happens
    edge_set_b_a: assert property (irq_b_edge_mode && b_edge |=> irq_b_pending_o)
        else $error("edge on B did not set flag");

    // Acknowledge clears flag A when no edge or write competes
    ack_release_a: assert property (
        irq_a_edge_mode && irq_a_ack_i && !a_edge && !timer_control_reg_wr |=> !irq_a_pending_o)
        else $error("ack did not clear flag A");

    // Software write sets or clears an edge flag when no edge arrives
    flag_write_a: assert property (
        irq_a_edge_mode && timer_control_reg_wr && !a_edge
        |=> irq_a_pending_o == $past(sfr_wdata_i[A_PEND_BIT]))
        else $error("software write to flag A lost");

    flag_write_b_a: assert property (
        irq_b_edge_mode && timer_control_reg_wr && !b_edge
        |=> irq_b_pending_o == $past(sfr_wdata_i[B_PEND_BIT]))
        else $error("software write to flag B lost");

    // A write in level mode cannot force the flag away from the input
    level_wr_ignore_a: assert property (
        !irq_b_edge_mode && timer_control_reg_wr |=> irq_b_pending_o == $past(b_active))
        else $error("level flag B took a software write");

    // Sense bits take the written value on the next edge
    mode_write_a: assert property (
        timer_control_reg_wr |=> irq_a_edge_mode == $past(sfr_wdata_i[A_MODE_BIT])
        && irq_b_edge_mode == $past(sfr_wdata_i[B_MODE_BIT]))
        else $error("sense bits not stored");

    // Same three-edge pin latency on input B
    pin_latency_b_a: assert property (
        !irq_b_edge_mode && $stable(cfg_r) && $stable(irq_b_edge_mode)
        ##1 $stable(cfg_r) && $stable(irq_b_edge_mode)
        ##1 $stable(cfg_r) && $stable(irq_b_edge_mode)
        |=> irq_b_pending_o ==
            ($past(port0_pins_i[irq_b_pin_select], 3) ~^ $past(irq_b_polarity)))
        else $error("pin to flag latency wrong on B");

    // Main scenarios
    cov_edge_ack_c: cover property (a_edge && irq_a_edge_mode ##[1:20] irq_a_ack_i);
    cov_level_b_c: cover property (!irq_b_edge_mode && irq_b_pending_o ##[1:20] !irq_b_pending_o);
    cov_high_pol_c: cover property (irq_a_polarity && irq_a_pending_o);
    cov_pin_change_c: cover property (cfg_wr ##1 irq_b_pin_select == 3'h7);
    cov_set_wins_c: cover property (a_edge && irq_a_edge_mode && irq_a_ack_i);

endmodule

`default_nettype wire

// file: bench/irq_source.sv
// Purpose: Behavioural external interrupt source on the port-0 pins.
// Assumes: Push-pull pins, changed just after a falling clock edge.
// Notes:   A level request waits a bounded time for the acknowledge.

`timescale 1ns/1ps
`default_nettype none

module irq_source (
    // Clock and acknowledge seen from the core
    input wire logic sys_clk_i,
    input wire logic ack_i,
    // Port 0 pins
    output logic [7:0] pins_o
);
    // ********************************************************
    // Pin drivers
    // ********************************************************
    logic [7:0] pins_r = 8'hff;

    assign pins_o = pins_r;

    // Whole port update, always off the sampling edge
    task automatic set_pins(input logic [7:0] v);
        @(negedge sys_clk_i);
        pins_r = v;
    endtask

    // Hold the request until the vector acknowledge, then drop it on the next falling edge
    task automatic level_request(input int idx, input logic act, output logic ok);
        ok = 1'b0;
        @(negedge sys_clk_i);
        pins_r[idx] = act;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge sys_clk_i);
            ok = (ack_i === 1'b1);
        end
        @(negedge sys_clk_i);
        pins_r[idx] = ~act;
    endtask
endmodule

`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for the external interrupt input logic.
// Assumes: Inputs change on the falling edge; pin latency is three edges.
// Notes:   Settling waits are fixed by the pin latency, not by polling.

`timescale 1ns/1ps
`default_nettype none

module tb;
    import ext_irq_pkg::*;

    logic sys_clk_i, rstn_i, sfr_wr_i, sfr_rd_i, ack_a, ack_b, pend_a, pend_b, ok;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, pins;
    int error_cnt = 0;
    int cmp_count = 0;

    ext_irq_input_logic uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .port0_pins_i(pins),
        .irq_a_ack_i(ack_a), .irq_b_ack_i(ack_b),
        .irq_a_pending_o(pend_a), .irq_b_pending_o(pend_b));

    irq_source src (.sys_clk_i(sys_clk_i), .ack_i(ack_a), .pins_o(pins));

    // 100 MHz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bus tasks are entered on a falling edge and leave on one
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        sfr_addr_i = addr;
        sfr_wdata_i = data;
        sfr_wr_i = 1'b1;
        @(negedge sys_clk_i);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        sfr_addr_i = addr;
        sfr_rd_i = 1'b1;
        @(negedge sys_clk_i);
        sfr_rd_i = 1'b0;
        @(negedge sys_clk_i);
        check(sfr_rdata_o, exp);
    endtask

    // Three edges of pin latency plus one spare
    task automatic settle();
        repeat (4) @(negedge sys_clk_i);
    endtask

    task automatic chk_pend(input logic [1:0] exp);
        check({6'h00, pend_a, pend_b}, {6'h00, exp});
    endtask

    // Hang guard
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t ns: run did not complete", $time);
        finish_test();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin : main
        logic [7:0] v;
        rstn_i = 1'b0;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        ack_a = 1'b0;
        ack_b = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        settle();
        rd_chk(CFG_ADDR, 8'h01);
        rd_chk(TIMER_CONTROL_REG_ADDR, 8'h00);
        rd_chk(8'h55, 8'h00);
        // Level mode, active high, every pin code on both inputs
        for (int n = 0; n < 8; n++) begin
            v = {1'b1, n[2:0], 1'b1, n[2:0]};
            wr_reg(CFG_ADDR, v);
            rd_chk(CFG_ADDR, v);
            src.set_pins(8'h01 << n);
            settle();
            chk_pend(2'b11);
            src.set_pins(~(8'h01 << n));
            settle();
            chk_pend(2'b00);
        end
        // Edge mode, active low: A on pin 2, B on pin 5
        wr_reg(CFG_ADDR, 8'h52);
        src.set_pins(8'hff);
        wr_reg(TIMER_CONTROL_REG_ADDR, 8'h05);
        settle();
        wr_reg(TIMER_CONTROL_REG_ADDR, 8'h05); // Clears any edge from the mode change
        rd_chk(TIMER_CONTROL_REG_ADDR, 8'h05);
        src.set_pins(8'hfb);
        settle();
        rd_chk(TIMER_CONTROL_REG_ADDR, 8'h07);
        src.set_pins(8'hff);
        settle();
        chk_pend(2'b10);
        ack_a = 1'b1;
        @(negedge sys_clk_i);
        ack_a = 1'b0;
        chk_pend(2'b00);
        // Edge and acknowledge in one cycle: the set wins
        src.set_pins(8'hfb);
        repeat (2) @(negedge sys_clk_i);
        ack_a = 1'b1;
        @(negedge sys_clk_i);
        ack_a = 1'b0;
        chk_pend(2'b10);
        @(negedge sys_clk_i);
        ack_a = 1'b1;
        @(negedge sys_clk_i);
        ack_a = 1'b0;
        chk_pend(2'b00);
        src.set_pins(8'hdf);
        settle();
        rd_chk(TIMER_CONTROL_REG_ADDR, 8'h0d);
        ack_b = 1'b1;
        @(negedge sys_clk_i);
        ack_b = 1'b0;
        chk_pend(2'b00);
        // Edge mode, active high: rising edges count
        wr_reg(CFG_ADDR, 8'hda);
        src.set_pins(8'h00);
        settle();
        wr_reg(TIMER_CONTROL_REG_ADDR, 8'h05);
        src.set_pins(8'h04);
        settle();
        chk_pend(2'b10);
        src.set_pins(8'h24);
        settle();
        chk_pend(2'b11);
        // Back to level mode: the flags that this write sets give way to the pins
        src.set_pins(8'h00);
        wr_reg(TIMER_CONTROL_REG_ADDR, 8'h0a);
        settle();
        chk_pend(2'b00);
        // Level mode now: flag bits written are dropped
        wr_reg(TIMER_CONTROL_REG_ADDR, 8'h0a);
        chk_pend(2'b00);
        // Level request held until the acknowledge, then released
        fork
            src.level_request(2, 1'b1, ok);
            begin
                settle();
                chk_pend(2'b10);
                ack_a = 1'b1;
                @(negedge sys_clk_i);
                ack_a = 1'b0;
            end
        join
        chk_pend(2'b10);
        check({7'h00, ok}, 8'h01);
        settle();
        chk_pend(2'b00);
        // Read and write in one cycle: the read returns the old byte
        sfr_addr_i = CFG_ADDR;
        sfr_wdata_i = 8'h83;
        sfr_wr_i = 1'b1;
        sfr_rd_i = 1'b1;
        @(negedge sys_clk_i);
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        @(negedge sys_clk_i);
        check(sfr_rdata_o, 8'hda);
        rd_chk(CFG_ADDR, 8'h83);
        // Writes off the map leave the config alone
        wr_reg(8'h55, 8'hff);
        rd_chk(CFG_ADDR, 8'h83);
        // Mid-run reset: config and sense return to defaults, low pins read active
        rstn_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        settle();
        rd_chk(CFG_ADDR, 8'h01);
        rd_chk(TIMER_CONTROL_REG_ADDR, 8'h0a);
        finish_test();
    end
endmodule

`default_nettype wire
